/* File: dma_channel_sequencer_tb.sv */
// Self-checking bench of the DMA channel sequencer with a queue reference model.
`timescale 1ns/1ps
module dma_channel_sequencer_tb;
	// ==================================================================
	// Signals carry the port names, so instances connect by name.
	logic clock = 1'b0, rst = 1'b1, desc_load = 1'b0, txn_valid, txn_ready;
	logic [3:0] ext_transfer_request_n = 4'hF, link_tx_request = 4'h0, link_rx_request = 4'h0;
	logic [1:0] autodma_write = 2'h0;
	logic [4:0] desc_load_slot = 5'h00;
	logic [127:0] desc_load_word = 128'h0, chain_fetch_word;
	logic [3:0] txn_channel, size_mismatch;
	logic [31:0] txn_src_addr, txn_dst_addr, base, seed = 32'h16241;
	logic txn_on_internal_bus, txn_to_bus_unit, txn_flyby, txn_feedthrough, chain_fetch_valid;
	logic flyby_read_strobe, flyby_write_strobe, flyby_output_enable, chain_fetch_done;
	logic [20:0] chain_fetch_addr;
	logic [13:0] channel_active, channel_done, block_done_pulse;
	logic [71:0] exp_q[$]; // Channel, addresses and path bits of each offer yet to come.
	int fail_count = 0, n_checks = 0;
	dsq_sequencer dut (.*);
	dsq_far_model u_far (.*);
	always #50 clock = ~clock;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic check(input string what, input logic [71:0] exp, input logic [71:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	// Descriptor writes are single-cycle strobes driven on the falling edge.
	task automatic load(input logic [4:0] slot, input logic [31:0] idx, x, ctl);
		@(negedge clock);
		desc_load = 1'b1;
		desc_load_slot = slot;
		desc_load_word = {ctl, 32'h0, x, idx};
		@(negedge clock);
		desc_load = 1'b0;
	endtask : load
	// Bounded wait for the model queue; a hang counts and ends the run.
	task automatic drain();
		for (int i = 0; i < 300 && exp_q.size() > 0; i++) @(negedge clock);
		if (exp_q.size() > 0) begin
			check("drain", 72'h0, 72'(exp_q.size()));
			end_sim();
		end
		repeat (20) @(negedge clock);
	endtask : drain
	// Every taken offer must be the next one the model predicts.
	always @(posedge clock) if (txn_valid === 1'b1 && txn_ready === 1'b1)
		check("offer", exp_q.size() ? exp_q.pop_front() : '1,
			{txn_channel, txn_src_addr, txn_dst_addr,
			txn_on_internal_bus, txn_to_bus_unit, txn_flyby, txn_feedthrough});
	// ==================================================================
	// Scenarios.
	initial begin
		repeat (20) @(negedge clock);
		rst = 1'b0;
		link_rx_request = 4'h1;
		@(negedge clock);
		link_rx_request = 4'h0;
		repeat (10) @(negedge clock);
		check("active", 72'h0, 72'(channel_active[8]));
		// Arming now must not revive the dropped request as an offer.
		load(5'h08, 32'h0000_0200, 32'h0001_0001, 32'h2000_0000);
		$display("uninitialised request done");
		seed = lfsr(seed);
		base = {16'h0, seed[15:4], 4'h0};
		load(5'h04, base, 32'h0003_0001, 32'h2300_0123);
		for (int i = 0; i < 3; i++) exp_q.push_back({4'h4, base + 32'(i), 32'h0, 4'h8});
		link_tx_request = 4'h1;
		repeat (3) @(negedge clock);
		link_tx_request = 4'h0;
		drain();
		check("done", 72'h10, 72'(channel_done));
		check("chain", 72'h48C, 72'({channel_active[8], chain_fetch_addr}));
		$display("link block done");
		load(5'h00, 32'h0400_0010, 32'h0002_0001, 32'h2C80_0000);
		load(5'h0E, 32'h0000_0100, 32'h0002_0001, 32'h2000_0000);
		for (int i = 0; i < 2; i++) begin
			exp_q.push_back({4'h0, 32'h0400_0010 + 32'(i), 32'h0000_0100 + 32'(i), 4'h6});
			seed = lfsr(seed);
			ext_transfer_request_n = 4'hE;
			repeat (2 + seed[2:0]) @(negedge clock);
			ext_transfer_request_n = 4'hF;
			repeat (8) @(negedge clock);
		end
		drain();
		check("mismatch", 72'h0, 72'(size_mismatch));
		$display("external flyby done");
		load(5'h05, base, 32'h0002_0001, 32'h2000_0000);
		load(5'h05, 32'h0, 32'h0, 32'h0);
		link_tx_request = 4'h2;
		@(negedge clock);
		link_tx_request = 4'h0;
		repeat (10) @(negedge clock);
		check("active", 72'h0, 72'(channel_active[5]));
		$display("idle reload done");
		load(5'h09, 32'h001F_0000, 32'h0001_0001, 32'h2000_0000);
		load(5'h0C, 32'h0000_0300, 32'h0001_0001, 32'h2000_0000);
		exp_q.push_back({4'h9, 32'h0, 32'h001F_0000, 4'h9});
		exp_q.push_back({4'hC, 32'h0, 32'h0000_0300, 4'h8});
		link_rx_request = 4'h2;
		autodma_write = 2'h1;
		@(negedge clock);
		link_rx_request = 4'h0;
		autodma_write = 2'h0;
		drain();
		$display("feedthrough and target write done");
		end_sim();
	end
endmodule : dma_channel_sequencer_tb

/* File: dsq_consts.svh */
// Field positions, codes and limits shared by the DMA channel sequencer files.
`ifndef DSQ_CONSTS_SVH
`define DSQ_CONSTS_SVH

// =====================================================================
// Descriptor quad-word layout: word 0 index, 1 X, 2 Y, 3 control.
`define DSQ_W_IDX_HI   31
`define DSQ_W_IDX_LO   0
`define DSQ_W_X_HI     63
`define DSQ_W_X_LO     32
`define DSQ_W_Y_HI     95
`define DSQ_W_Y_LO     64
`define DSQ_W_CTL_HI   127
`define DSQ_W_CTL_LO   96

// =====================================================================
// Dimension word fields: count high half, modifier low half.
`define DSQ_CNT_HI     31
`define DSQ_CNT_LO     16
`define DSQ_MOD_HI     15
`define DSQ_MOD_LO     0

// =====================================================================
// Control word fields.
`define DSQ_TY_HI      31
`define DSQ_TY_LO      29
`define DSQ_BIT_2D     28
`define DSQ_BIT_HSK    27
`define DSQ_BIT_FLY    26
`define DSQ_BIT_DONE   25
`define DSQ_BIT_CHAIN  24
`define DSQ_BIT_FLYDIR 23
`define DSQ_CHTG_HI    21
`define DSQ_CHTG_LO    19
`define DSQ_NEXT_DESCRIPTOR_POINTER_HI    18
`define DSQ_NEXT_DESCRIPTOR_POINTER_LO    0

// =====================================================================
// Codes, limits and address regions.
`define DSQ_TY_IDLE    3'h0
`define DSQ_REQ_MAX    4'hF
`define DSQ_EXT_BASE   32'h04000000
`define DSQ_LTX_TAG    16'h001F
`define DSQ_NUM_CH     14
`define DSQ_NUM_SLOT   18
`define DSQ_DST_FIRST  5'h0E

`endif

/* File: dsq_dim_walker.sv */
// Next-address and count step of one descriptor in one or two dimensions.
`timescale 1ns/1ps
`include "dsq_consts.svh"
module dsq_dim_walker (
	input  wire logic [31:0] index,
	input  wire logic [31:0] x_word,
	input  wire logic [31:0] y_word,
	input  wire logic        two_d,
	input  wire logic [15:0] x_left,
	input  wire logic [15:0] y_left,
	output logic      [31:0] next_index,
	output logic      [15:0] next_x_left,
	output logic      [15:0] next_y_left,
	output logic             last
);
	logic row_end;

	assign row_end = (x_left <= 16'h0001);
	assign last = row_end && (!two_d || (y_left <= 16'h0001));

	// ====================================================================
	// Step: X modifier inside a row, Y modifier from row end to next row start.
	always_comb begin
		next_index = index + {{16{x_word[`DSQ_MOD_HI]}}, x_word[`DSQ_MOD_HI:`DSQ_MOD_LO]};
		next_x_left = x_left - 16'h0001;
		next_y_left = y_left;
		if (row_end) begin
			next_index = index + {{16{y_word[`DSQ_MOD_HI]}}, y_word[`DSQ_MOD_HI:`DSQ_MOD_LO]};
			next_x_left = x_word[`DSQ_CNT_HI:`DSQ_CNT_LO];
			next_y_left = y_left - 16'h0001;
		end
	end
endmodule : dsq_dim_walker

/* File: dsq_far_model.sv */
// Far-side model: takes offers after a varying delay and answers descriptor fetches.
`timescale 1ns/1ps
module dsq_far_model (
	input wire logic     clock,
	input wire logic     rst,
	input wire logic     txn_valid,
	output logic         txn_ready,
	input wire logic     chain_fetch_valid,
	output logic         chain_fetch_done,
	output logic [127:0] chain_fetch_word
);
	logic [2:0] tick; // Free counter, so the accept delay differs between offers.
	// Ready is raised only for a standing offer and lowered right after the take.
	always_ff @(posedge clock) begin
		tick <= rst ? 3'h0 : tick + 3'h1;
		txn_ready <= !rst && txn_valid && !txn_ready && tick[1];
	end
	// A fetch is answered with an idle descriptor; the word churns when not valid.
	always_ff @(posedge clock) begin
		chain_fetch_done <= !rst && chain_fetch_valid && !chain_fetch_done;
		chain_fetch_word <= (rst || chain_fetch_valid) ? 128'h0 : ~chain_fetch_word;
	end
endmodule : dsq_far_model

/* File: dsq_pkg.sv */
// Types shared by the DMA channel sequencer files.
package dsq_pkg;
	// Sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ISSUE,
		ST_FETCH
	} dsq_state_e;
	// Descriptor slot number, channel number and request count.
	typedef logic [4:0] dsq_slot_t;
	typedef logic [3:0] dsq_chan_t;
	typedef logic [3:0] dsq_cnt_t;
endpackage : dsq_pkg

/* File: dsq_req_counter.sv */
// Per-channel accumulator of request pulses.
`timescale 1ns/1ps
`include "dsq_consts.svh"
module dsq_req_counter (
	input  wire logic            clock,
	input  wire logic            rst,
	input  wire logic            flush,    // Descriptor reset empties the count.
	input  wire logic            armed,    // Channel initialised.
	input  wire logic            req,      // One request pulse.
	input  wire logic            take,     // One request-driven transaction issued.
	output dsq_pkg::dsq_cnt_t    count,
	output logic                 pending
);
	logic add;

	// A request on an uninitialised channel never reaches the count.
	assign add = req && armed;
	assign pending = (count != 4'h0);

	// ====================================================================
	// Counter: saturates at its ceiling, a request and a take together cancel.
	always_ff @(posedge clock) begin
		if (rst || flush) begin
			count <= 4'h0;
		end else if (add && !take) begin
			if (count != `DSQ_REQ_MAX) begin
				count <= count + 4'h1;
			end
		end else if (take && !add && pending) begin
			count <= count - 4'h1;
		end
	end
endmodule : dsq_req_counter

/* File: dsq_sequencer.sv */
// Multi-channel DMA sequencer: descriptors, request pacing, issue and chaining.
//
// Notes on behaviour
// - Count up to fifteen requests, one transaction each.
// - Programmed descriptor starts; continuous or per request.
// - Requests on uninitialised channels are ignored.
// - External request pins count falling edges only.
// - Flyby runs bus cycle, strobes steer device.
// - AutoDMA write raises request, data goes to memory.
// - Link transmit request gets one memory-to-link transfer.
// - Link receive request gets one link-to-memory transfer.
// - Link, AutoDMA request-driven; external either mode.
// - Sequencer initiates; transmitter source, receiver destination.
// - Link or internal source: internal bus; else bus unit.
// - One descriptor per link/AutoDMA; external uses pair.
// - Receive link aimed at transmit buffer feeds through.
// - Own X/Y per side; totals must match.
// - Two-dimensional walking for link and AutoDMA memory.
// - Finished block fetches next descriptor from pointer.
// - Link chain may load another link channel.
// - New descriptor may be inserted into active chain.
// - AutoDMA targets are virtual, feed channel block.
// - Dimension word: count high half, modifier low.
// - Idle type code resets channel, flushes requests; a chain-loaded idle word keeps the request count.
// - Optional completion flag after last element moved.
// - Pointer gives address bits twenty to two.
`timescale 1ns/1ps
`include "dsq_consts.svh"
module dsq_sequencer (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic [3:0]   ext_transfer_request_n,  // External channels 0-3, active low.
	input  wire logic [3:0]   link_tx_request,         // Transmit links ready for data.
	input  wire logic [3:0]   link_rx_request,         // Receive links holding data.
	input  wire logic [1:0]   autodma_write,           // Bus master wrote a target.
	input  wire logic         desc_load,               // Descriptor write strobe.
	input  wire logic [4:0]   desc_load_slot,          // Slot 0-13 channel, 14-17 ext dest.
	input  wire logic [127:0] desc_load_word,          // Quad-word descriptor.
	output logic              txn_valid,
	input  wire logic         txn_ready,
	output logic [3:0]        txn_channel,
	output logic [31:0]       txn_src_addr,
	output logic [31:0]       txn_dst_addr,
	output logic              txn_on_internal_bus,
	output logic              txn_to_bus_unit,
	output logic              txn_flyby,
	output logic              txn_feedthrough,
	output logic              flyby_read_strobe,
	output logic              flyby_write_strobe,
	output logic              flyby_output_enable,
	output logic              chain_fetch_valid,
	output logic [20:0]       chain_fetch_addr,
	input  wire logic         chain_fetch_done,
	input  wire logic [127:0] chain_fetch_word,
	output logic [13:0]       channel_active,
	output logic [13:0]       channel_done,
	output logic [13:0]       block_done_pulse,
	output logic [3:0]        size_mismatch
);
	// ====================================================================
	// Descriptor storage, one entry per slot.
	logic [31:0] d_index [`DSQ_NUM_SLOT];  // Current address.
	logic [31:0] d_x     [`DSQ_NUM_SLOT];  // X count and modifier.
	logic [31:0] d_y     [`DSQ_NUM_SLOT];  // Y count and modifier.
	logic [31:0] d_ctl   [`DSQ_NUM_SLOT];  // Control and chain fields.
	logic [15:0] d_xl    [`DSQ_NUM_SLOT];  // Elements left in the row.
	logic [15:0] d_yl    [`DSQ_NUM_SLOT];  // Rows left.
	logic [`DSQ_NUM_SLOT-1:0] live;        // Slot holds a non-idle type.

	// ====================================================================
	// Sequencer state.
	dsq_pkg::dsq_state_e state;            // Main state.
	dsq_pkg::dsq_chan_t  sel;              // Channel being served.
	dsq_pkg::dsq_chan_t  pick;             // Highest-priority eligible channel.
	dsq_pkg::dsq_chan_t  cur;              // Channel whose walkers are shown.
	dsq_pkg::dsq_slot_t  slot_a;           // Source, or the only, slot.
	dsq_pkg::dsq_slot_t  slot_b;           // Destination slot of a pair.
	dsq_pkg::dsq_slot_t  fetch_slot;       // Slot a chain fetch will fill.
	logic                any_elig;         // Some channel may issue.
	logic [13:0]         ch_init;          // Channel initialised.
	logic [13:0]         elig;             // Channel may issue now.
	logic [13:0]         pending;          // Requests waiting per channel.
	logic [13:0]         req_event;        // Request pulse per channel.
	logic [13:0]         flush_ch;         // Idle descriptor loaded.
	logic [3:0]          mism;             // Pair totals differ.
	logic [3:0]          prev_req_n;       // Last sampled pin levels.
	logic                take_pulse;       // Transaction accepted.
	logic                abort;            // Served channel reset mid-issue.
	logic                fetch_hit;        // Chain word arrives.
	logic                done_now;         // Accepted transaction ends the block.

	// Walker results for the two slots.
	logic [31:0] wa_index;
	logic [15:0] wa_xl;
	logic [15:0] wa_yl;
	logic        wa_last;
	logic [31:0] wb_index;
	logic [15:0] wb_xl;
	logic [15:0] wb_yl;
	logic        wb_last;

	// ====================================================================
	// Slot mapping: external channels use a pair, others one slot.
	assign cur    = (state == dsq_pkg::ST_IDLE) ? pick : sel;
	assign slot_a = {1'b0, cur};
	assign slot_b = (cur < 4'h4) ? ({1'b0, cur} + `DSQ_DST_FIRST) : {1'b0, cur};

	// Chain target: link channels may name another link channel.
	function automatic dsq_pkg::dsq_slot_t chain_target(input dsq_pkg::dsq_chan_t c,
			input logic [31:0] ctl);
		logic [2:0] tg;
		tg = ctl[`DSQ_CHTG_HI:`DSQ_CHTG_LO];
		if ((c >= 4'h4) && (c <= 4'hB)) begin
			chain_target = tg[2] ? {3'h1, tg[1:0]} : {3'h2, tg[1:0]};
		end else begin
			chain_target = {1'b0, c};
		end
	endfunction : chain_target

	// ====================================================================
	// Address walkers for source and destination.
	dsq_dim_walker u_walk_a (
		.index       (d_index[slot_a]),
		.x_word      (d_x[slot_a]),
		.y_word      (d_y[slot_a]),
		.two_d       (d_ctl[slot_a][`DSQ_BIT_2D]),
		.x_left      (d_xl[slot_a]),
		.y_left      (d_yl[slot_a]),
		.next_index  (wa_index),
		.next_x_left (wa_xl),
		.next_y_left (wa_yl),
		.last        (wa_last)
	);

	dsq_dim_walker u_walk_b (
		.index       (d_index[slot_b]),
		.x_word      (d_x[slot_b]),
		.y_word      (d_y[slot_b]),
		.two_d       (d_ctl[slot_b][`DSQ_BIT_2D]),
		.x_left      (d_xl[slot_b]),
		.y_left      (d_yl[slot_b]),
		.next_index  (wb_index),
		.next_x_left (wb_xl),
		.next_y_left (wb_yl),
		.last        (wb_last)
	);

	// ====================================================================
	// Control strobes of the issue path.
	assign abort      = desc_load && (state == dsq_pkg::ST_ISSUE)
		&& (desc_load_word[`DSQ_TY_HI:`DSQ_TY_LO] == `DSQ_TY_IDLE)
		&& ((desc_load_slot == {1'b0, sel}) || (desc_load_slot == slot_b));
	assign take_pulse = (state == dsq_pkg::ST_ISSUE) && txn_ready && !abort;
	assign done_now   = take_pulse && wa_last;
	assign fetch_hit  = (state == dsq_pkg::ST_FETCH) && chain_fetch_done;

	// ====================================================================
	// Descriptor slots. A software load wins over a chain word, which wins
	// over an address step; a load into a running chain is how a priority
	// block or a second chain is inserted.
	genvar s;
	generate
		for (s = 0; s < `DSQ_NUM_SLOT; s++) begin : g_slot
			always_ff @(posedge clock) begin
				if (rst) begin
					live[s]    <= 1'b0;
					d_index[s] <= 32'h00000000;
					d_x[s]     <= 32'h00000000;
					d_y[s]     <= 32'h00000000;
					d_ctl[s]   <= 32'h00000000;
					d_xl[s]    <= 16'h0000;
					d_yl[s]    <= 16'h0000;
				end else if (desc_load && (desc_load_slot == 5'(s))) begin
					// Programming a non-idle type makes the slot live at once; an external channel also needs its pair.
					live[s]    <= desc_load_word[`DSQ_TY_HI+96:`DSQ_TY_LO+96] != `DSQ_TY_IDLE;
					d_index[s] <= desc_load_word[`DSQ_W_IDX_HI:`DSQ_W_IDX_LO];
					d_x[s]     <= desc_load_word[`DSQ_W_X_HI:`DSQ_W_X_LO];
					d_y[s]     <= desc_load_word[`DSQ_W_Y_HI:`DSQ_W_Y_LO];
					d_ctl[s]   <= desc_load_word[`DSQ_W_CTL_HI:`DSQ_W_CTL_LO];
					d_xl[s]    <= desc_load_word[`DSQ_W_X_HI:`DSQ_W_X_LO+16];
					d_yl[s]    <= desc_load_word[`DSQ_W_Y_HI:`DSQ_W_Y_LO+16];
				end else if (fetch_hit && (fetch_slot == 5'(s))) begin
					// Chain word replaces the descriptor in the chain target slot.
					live[s]    <= chain_fetch_word[`DSQ_TY_HI+96:`DSQ_TY_LO+96] != `DSQ_TY_IDLE;
					d_index[s] <= chain_fetch_word[`DSQ_W_IDX_HI:`DSQ_W_IDX_LO];
					d_x[s]     <= chain_fetch_word[`DSQ_W_X_HI:`DSQ_W_X_LO];
					d_y[s]     <= chain_fetch_word[`DSQ_W_Y_HI:`DSQ_W_Y_LO];
					d_ctl[s]   <= chain_fetch_word[`DSQ_W_CTL_HI:`DSQ_W_CTL_LO];
					d_xl[s]    <= chain_fetch_word[`DSQ_W_X_HI:`DSQ_W_X_LO+16];
					d_yl[s]    <= chain_fetch_word[`DSQ_W_Y_HI:`DSQ_W_Y_LO+16];
				end else if (take_pulse && (slot_a == 5'(s))) begin
					d_index[s] <= wa_index;
					d_xl[s]    <= wa_xl;
					d_yl[s]    <= wa_yl;
					if (wa_last) begin
						live[s] <= 1'b0;
					end
				end else if (take_pulse && (slot_b == 5'(s))) begin
					// Destination walks its own shape; the source's end closes both.
					d_index[s] <= wb_index;
					d_xl[s]    <= wb_xl;
					d_yl[s]    <= wb_yl;
					if (done_now) begin
						live[s] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ====================================================================
	// Pin edge capture: the pins are level samples, requests are edges.
	always_ff @(posedge clock) begin
		if (rst) begin
			prev_req_n <= 4'hF;
		end else begin
			prev_req_n <= ext_transfer_request_n;
		end
	end

	// ====================================================================
	// Per-channel request sources, counters and readiness.
	genvar c;
	generate
		for (c = 0; c < `DSQ_NUM_CH; c++) begin : g_ch
			if (c < 4) begin : g_ext
				logic [31:0] tot_s;
				logic [31:0] tot_d;
				// A level held low gives one request, not one per cycle.
				assign req_event[c] = prev_req_n[c] && !ext_transfer_request_n[c];
				assign tot_s = {16'h0000, d_x[c][`DSQ_CNT_HI:`DSQ_CNT_LO]}
					* {16'h0000, d_ctl[c][`DSQ_BIT_2D] ? d_y[c][`DSQ_CNT_HI:`DSQ_CNT_LO] : 16'h0001};
				assign tot_d = {16'h0000, d_x[c+14][`DSQ_CNT_HI:`DSQ_CNT_LO]}
					* {16'h0000, d_ctl[c+14][`DSQ_BIT_2D] ? d_y[c+14][`DSQ_CNT_HI:`DSQ_CNT_LO] : 16'h0001};
				assign mism[c] = (tot_s != tot_d);
				assign ch_init[c] = live[c] && live[c+14] && !mism[c];
				assign flush_ch[c] = desc_load
					&& (desc_load_word[`DSQ_TY_HI+96:`DSQ_TY_LO+96] == `DSQ_TY_IDLE)
					&& ((desc_load_slot == 5'(c)) || (desc_load_slot == 5'(c + 14)));
				// Continuous mode needs no request; handshake needs a counted one.
				assign elig[c] = ch_init[c]
					&& (pending[c] || !d_ctl[c][`DSQ_BIT_HSK]);
			end else begin : g_int
				if (c < 8) begin : g_ltx
					assign req_event[c] = link_tx_request[c-4];
				end else if (c < 12) begin : g_lrx
					assign req_event[c] = link_rx_request[c-8];
				end else begin : g_auto
					assign req_event[c] = autodma_write[c-12];
				end
				assign ch_init[c] = live[c];
				assign flush_ch[c] = desc_load
					&& (desc_load_word[`DSQ_TY_HI+96:`DSQ_TY_LO+96] == `DSQ_TY_IDLE)
					&& (desc_load_slot == 5'(c));
				assign elig[c] = ch_init[c] && pending[c];
			end

			dsq_req_counter u_cnt (
				.clock   (clock),
				.rst     (rst),
				.flush   (flush_ch[c]),
				.armed   (ch_init[c]),
				.req     (req_event[c]),
				.take    (take_pulse && (sel == 4'(c))
					&& ((c >= 4) || d_ctl[c][`DSQ_BIT_HSK])),
				.count   (),
				.pending (pending[c])
			);
		end
	endgenerate

	// ====================================================================
	// Fixed priority: the lowest channel number wins. Simple and cheap, but
	// a busy low channel can starve higher ones.
	always_comb begin
		pick = 4'h0;
		any_elig = 1'b0;
		for (int i = `DSQ_NUM_CH - 1; i >= 0; i--) begin
			if (elig[i]) begin
				pick = 4'(i);
				any_elig = 1'b1;
			end
		end
	end

	// ====================================================================
	// Issue and chain-fetch sequencer; the sequencer always initiates.
	always_ff @(posedge clock) begin
		if (rst) begin
			state               <= dsq_pkg::ST_IDLE;
			sel                 <= 4'h0;
			fetch_slot          <= 5'h00;
			txn_valid           <= 1'b0;
			txn_channel         <= 4'h0;
			txn_src_addr        <= 32'h00000000;
			txn_dst_addr        <= 32'h00000000;
			txn_on_internal_bus <= 1'b0;
			txn_to_bus_unit     <= 1'b0;
			txn_flyby           <= 1'b0;
			txn_feedthrough     <= 1'b0;
			chain_fetch_valid   <= 1'b0;
			chain_fetch_addr    <= 21'h000000;
		end else begin
			case (state)
				dsq_pkg::ST_IDLE: begin
					if (any_elig) begin
						sel         <= pick;
						txn_valid   <= 1'b1;
						txn_channel <= pick;
						// Receive and AutoDMA sources are their own buffers.
						txn_src_addr <= (pick >= 4'h8) ? 32'h00000000 : d_index[slot_a];
						// Link transmit destinations are the link buffer.
						txn_dst_addr <= (pick < 4'h4) ? d_index[slot_b]
							: ((pick < 4'h8) ? 32'h00000000 : d_index[slot_a]);
						txn_on_internal_bus <= (pick >= 4'h4)
							|| (d_index[slot_a] < `DSQ_EXT_BASE);
						txn_to_bus_unit <= (pick < 4'h4)
							&& (d_index[slot_a] >= `DSQ_EXT_BASE);
						txn_flyby <= (pick < 4'h4) && d_ctl[slot_a][`DSQ_BIT_FLY];
						txn_feedthrough <= (pick >= 4'h8) && (pick < 4'hC)
							&& (d_index[slot_a][31:16] == `DSQ_LTX_TAG);
						state <= dsq_pkg::ST_ISSUE;
					end
				end
				dsq_pkg::ST_ISSUE: begin
					if (abort) begin
						txn_valid <= 1'b0;
						state     <= dsq_pkg::ST_IDLE;
					end else if (txn_ready) begin
						txn_valid <= 1'b0;
						if (wa_last && d_ctl[slot_a][`DSQ_BIT_CHAIN]) begin
							chain_fetch_valid <= 1'b1;
							chain_fetch_addr  <= {d_ctl[slot_a][`DSQ_NEXT_DESCRIPTOR_POINTER_HI:`DSQ_NEXT_DESCRIPTOR_POINTER_LO], 2'b00};
							fetch_slot        <= chain_target(sel, d_ctl[slot_a]);
							state             <= dsq_pkg::ST_FETCH;
						end else begin
							state <= dsq_pkg::ST_IDLE;
						end
					end
				end
				dsq_pkg::ST_FETCH: begin
					if (chain_fetch_done) begin
						chain_fetch_valid <= 1'b0;
						state             <= dsq_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= dsq_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ====================================================================
	// Flyby strobes: the device moves the data, the sequencer never touches it.
	always_ff @(posedge clock) begin
		if (rst) begin
			flyby_read_strobe   <= 1'b0;
			flyby_write_strobe  <= 1'b0;
			flyby_output_enable <= 1'b0;
		end else if ((state == dsq_pkg::ST_IDLE) && any_elig && (pick < 4'h4)
				&& d_ctl[slot_a][`DSQ_BIT_FLY]) begin
			flyby_output_enable <= d_ctl[slot_a][`DSQ_BIT_FLYDIR];
			flyby_read_strobe   <= d_ctl[slot_a][`DSQ_BIT_FLYDIR];
			flyby_write_strobe  <= !d_ctl[slot_a][`DSQ_BIT_FLYDIR];
		end else if (take_pulse || abort) begin
			flyby_read_strobe   <= 1'b0;
			flyby_write_strobe  <= 1'b0;
			flyby_output_enable <= 1'b0;
		end
	end

	// ====================================================================
	// Completion flags: sticky until the channel is programmed again; a
	// completion in the same cycle as a reload still wins.
	always_ff @(posedge clock) begin
		if (rst) begin
			channel_done     <= 14'h0000;
			block_done_pulse <= 14'h0000;
		end else begin
			for (int i = 0; i < `DSQ_NUM_CH; i++) begin
				if (done_now && (sel == 4'(i)) && d_ctl[slot_a][`DSQ_BIT_DONE]) begin
					channel_done[i]     <= 1'b1;
					block_done_pulse[i] <= 1'b1;
				end else begin
					block_done_pulse[i] <= 1'b0;
					if (desc_load && ((desc_load_slot == 5'(i))
							|| ((i < 4) && (desc_load_slot == 5'(i + 14))))) begin
						channel_done[i] <= 1'b0;
					end
				end
			end
		end
	end

	// ====================================================================
	// Status mirrors.
	always_ff @(posedge clock) begin
		if (rst) begin
			channel_active <= 14'h0000;
			size_mismatch  <= 4'h0;
		end else begin
			channel_active <= ch_init;
			size_mismatch  <= mism & live[3:0] & live[17:14];
		end
	end
endmodule : dsq_sequencer

/* File: dsq_sequencer_asserts.sv */
// Port-level checker of the DMA channel sequencer, bound to its top module.
`timescale 1ns/1ps
module dsq_seq_chk (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        desc_load,
	input wire logic        txn_valid,
	input wire logic        txn_ready,
	input wire logic [31:0] txn_src_addr,
	input wire logic        txn_flyby,
	input wire logic        flyby_read_strobe,
	input wire logic        flyby_write_strobe,
	input wire logic        flyby_output_enable,
	input wire logic        chain_fetch_valid,
	input wire logic        chain_fetch_done,
	input wire logic [20:0] chain_fetch_addr,
	input wire logic [13:0] channel_done,
	input wire logic [13:0] block_done_pulse
);
	// ==================================================================
	// Offer handshake, flyby strobes, chain fetch and completion.
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// An idle descriptor load may withdraw a standing offer, so a load cycle is exempt.
	a_offer_hold: assert property (txn_valid && !txn_ready && !desc_load |=>
		txn_valid && $stable(txn_src_addr)) else $error("offer changed before taken");
	a_offer_gap: assert property (txn_valid && txn_ready |=> !txn_valid)
		else $error("offer not withdrawn");
	a_fly_read: assert property ($rose(flyby_read_strobe) |-> txn_valid && txn_flyby)
		else $error("read strobe without flyby offer");
	a_fly_excl: assert property (!(flyby_write_strobe && flyby_read_strobe))
		else $error("both flyby strobes high");
	a_fly_oe: assert property (flyby_output_enable == flyby_read_strobe)
		else $error("output enable apart from read strobe");
	a_chain_hold: assert property (chain_fetch_valid && !chain_fetch_done |=>
		chain_fetch_valid && $stable(chain_fetch_addr)) else $error("fetch dropped");
	a_chain_end: assert property (chain_fetch_valid && chain_fetch_done |=> !chain_fetch_valid)
		else $error("fetch not ended");
	a_chain_align: assert property (chain_fetch_valid |-> chain_fetch_addr[1:0] == 2'h0)
		else $error("fetch address unaligned");
	a_done_flag: assert property (block_done_pulse != 14'h0 |->
		(block_done_pulse & ~channel_done) == 14'h0) else $error("pulse without flag");
	c_accept: cover property (txn_valid && txn_ready);
	c_flyby: cover property (flyby_read_strobe && txn_ready);
	c_done: cover property (block_done_pulse != 14'h0);
endmodule : dsq_seq_chk
bind dsq_sequencer dsq_seq_chk u_chk (.*);
